// ===== arss_defs.vh
// Constants for the rotate, subtract, swap and sleep datapath
`ifndef ARSS_DEFS_VH
`define ARSS_DEFS_VH

// APB byte addresses
`define ARSS_A_CMD     8'h00
`define ARSS_A_ACC     8'h04
`define ARSS_A_STAT    8'h08
`define ARSS_A_FSEL    8'h0c
`define ARSS_A_FDATA   8'h10
`define ARSS_A_WDOG    8'h14
`define ARSS_A_CTRL    8'h18

// Command register fields
`define ARSS_CMD_OP_LSB   0
`define ARSS_CMD_OP_MSB   2
`define ARSS_CMD_DEST     3
`define ARSS_CMD_FA_LSB   4
`define ARSS_CMD_FA_MSB   8

// Operation codes
`define ARSS_OP_ROTL   3'h0
`define ARSS_OP_ROTR   3'h1
`define ARSS_OP_SUB    3'h2
`define ARSS_OP_SWAP   3'h3
`define ARSS_OP_SLEEP  3'h4

// Status register bits
`define ARSS_ST_C      0
`define ARSS_ST_DC     1
`define ARSS_ST_Z      2
`define ARSS_ST_EXP    3
`define ARSS_ST_SLP    4
`define ARSS_ST_WAKE   5
`define ARSS_ST_BUSY   6
`define ARSS_ST_ASLEEP 7

// Control register bits
`define ARSS_CT_WDT_EN 0
`define ARSS_CT_WAKE   1

// Reset and load values
`define ARSS_WDT_CLR   8'h00
`define ARSS_PRE_CLR   8'h00

`endif

// ===== arss_fram.v
// File register memory, 32 words of 8 bits with registered read
`timescale 1ns/1ps
`default_nettype none

module arss_fram #(
  parameter AW = 5,
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata_ff,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are not reset; software initialises them
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= {DW{1'b0}};
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule // arss_fram

`default_nettype wire

// ===== arss_alu.v
// Combinational rotate, subtract and nibble exchange unit
`timescale 1ns/1ps
`default_nettype none
`include "arss_defs.vh"

module arss_alu (
  input  wire [2:0] op,
  input  wire [7:0] fval,
  input  wire [7:0] acc,
  input  wire       c_in,
  output reg  [7:0] result,
  output reg        c_out,
  output reg        dc_out,
  output wire       z_out,
  output reg        upd_c,
  output reg        upd_dcz
);

  reg [8:0] diff;
  reg [4:0] ndiff;

  assign z_out = (result == 8'h00);

  always @* begin
    diff    = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
    ndiff   = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    result  = fval;
    c_out   = c_in;
    dc_out  = 1'b0;
    upd_c   = 1'b0;
    upd_dcz = 1'b0;
    case (op)
      `ARSS_OP_ROTL: begin
        result = {fval[6:0], c_in};
        c_out  = fval[7];
        upd_c  = 1'b1;
      end
      `ARSS_OP_ROTR: begin
        result = {c_in, fval[7:1]};
        c_out  = fval[0];
        upd_c  = 1'b1;
      end
      // f minus acc, carry means no borrow
      `ARSS_OP_SUB: begin
        result  = diff[7:0];
        c_out   = diff[8];
        dc_out  = ndiff[4];
        upd_c   = 1'b1;
        upd_dcz = 1'b1;
      end
      `ARSS_OP_SWAP: begin
        result = {fval[3:0], fval[7:4]};
      end
      default: begin
        result = fval;
      end
    endcase
  end

endmodule // arss_alu

`default_nettype wire

// ===== arss_core.v
// Datapath for rotate, subtract, nibble exchange and sleep with APB registers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "arss_defs.vh"

// Operation
// - Sleep clears watchdog counter and its prescaler to zero.
// - Sleep sets the active-low expiry status bit to one; here a watchdog overflow in the same cycle takes priority and holds it at zero.
// - Sleep clears the active-low sleep status bit to zero.
// - Sleep leaves the pin-change wake flag untouched.
// - Sleep enters low power with oscillator halted; takes no operand.
// - Destination bit zero writes accumulator, one writes file register 0..31.
// - Rotate left through carry; only carry changes.
// - Rotate right through carry; only carry changes.
// - Subtract accumulator from file operand; updates carry, half carry, zero.
// - Nibble exchange swaps operand halves; no flag changes.
module arss_core #(
  parameter PRE_W = 8,
  parameter WDT_W = 8
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata_ff,
  input  wire        wake_pin,
  output wire        osc_run,
  output wire        low_power
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_EXEC  = 2'h2;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `ARSS_A_CMD) || (a == `ARSS_A_ACC) ||
                  (a == `ARSS_A_STAT) || (a == `ARSS_A_FSEL) ||
                  (a == `ARSS_A_FDATA) || (a == `ARSS_A_WDOG) ||
                  (a == `ARSS_A_CTRL);
    end
  endfunction

  function needs_idle;
    input [7:0] a;
    begin
      needs_idle = (a == `ARSS_A_CMD) || (a == `ARSS_A_FDATA);
    end
  endfunction

  reg [1:0]       state_ff;
  reg [1:0]       nxt_state;
  reg [8:0]       cmd_ff;
  reg [7:0]       acc_ff;
  reg [4:0]       fsel_ff;
  reg             c_ff;
  reg             dc_ff;
  reg             z_ff;
  reg             expiry_status_bit_ff;
  reg             sleep_status_bit_ff;
  reg             pin_change_wake_flag_ff;
  reg             asleep_ff;
  reg             wdt_en_ff;
  reg [PRE_W-1:0] pre_ff;
  reg [WDT_W-1:0] watchdog_counter_ff;
  reg             rd_ok_ff;
  reg             pin_s1_ff;
  reg             pin_s2_ff;
  reg             pin_s3_ff;
  reg             pin_st_ff;

  wire       busy     = (state_ff != ST_IDLE);
  wire       stall    = busy && needs_idle(paddr);
  wire       wr_take  = pready && pwrite;
  wire [2:0] cmd_op   = pwdata[`ARSS_CMD_OP_MSB:`ARSS_CMD_OP_LSB];
  wire       cmd_wr   = wr_take && (paddr == `ARSS_A_CMD) && !asleep_ff;
  wire       slp_cmd  = cmd_wr && (cmd_op == `ARSS_OP_SLEEP);
  wire       exe_cmd  = cmd_wr && (cmd_op != `ARSS_OP_SLEEP);
  wire       ctl_wr   = wr_take && (paddr == `ARSS_A_CTRL);
  wire       stat_wr  = wr_take && (paddr == `ARSS_A_STAT);
  wire       fdat_wr  = wr_take && (paddr == `ARSS_A_FDATA);
  wire [4:0] cmd_fa   = cmd_ff[`ARSS_CMD_FA_MSB:`ARSS_CMD_FA_LSB];
  wire       cmd_dest = cmd_ff[`ARSS_CMD_DEST];
  wire [2:0] run_op   = cmd_ff[`ARSS_CMD_OP_MSB:`ARSS_CMD_OP_LSB];
  wire       pre_wrap = wdt_en_ff && (pre_ff == {PRE_W{1'b1}});
  wire       wdt_ovf  = pre_wrap && (watchdog_counter_ff == {WDT_W{1'b1}});
  wire       pin_chg  = (pin_s2_ff == pin_s3_ff) && (pin_s3_ff != pin_st_ff);
  wire       pin_wake = asleep_ff && pin_chg;
  wire       sw_wake  = ctl_wr && pwdata[`ARSS_CT_WAKE];
  wire       exec     = (state_ff == ST_EXEC);

  wire [7:0] f_rdata;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_z;
  wire       alu_upd_c;
  wire       alu_upd_dcz;

  // result to file register when dest set
  wire       f_we    = (exec && cmd_dest) || fdat_wr;
  wire [4:0] f_waddr = exec ? cmd_fa : fsel_ff;
  wire [7:0] f_wdata = exec ? alu_res : pwdata[7:0];
  wire [4:0] f_raddr = (state_ff == ST_FETCH) ? cmd_fa : fsel_ff;

  assign pready    = psel && penable && rd_ok_ff;
  assign pslverr   = pready && !is_mapped(paddr);
  assign osc_run   = !asleep_ff;
  assign low_power = asleep_ff;

  arss_fram #(
    .AW (5),
    .DW (8)
  ) u_fram (
    .pclk     (pclk),
    .presetn  (presetn),
    .raddr    (f_raddr),
    .rdata_ff (f_rdata),
    .we       (f_we),
    .waddr    (f_waddr),
    .wdata    (f_wdata)
  );

  arss_alu u_alu (
    .op      (run_op),
    .fval    (f_rdata),
    .acc     (acc_ff),
    .c_in    (c_ff),
    .result  (alu_res),
    .c_out   (alu_c),
    .dc_out  (alu_dc),
    .z_out   (alu_z),
    .upd_c   (alu_upd_c),
    .upd_dcz (alu_upd_dcz)
  );

  always @* begin
    case (state_ff)
      ST_IDLE:  nxt_state = exe_cmd ? ST_FETCH : ST_IDLE;
      ST_FETCH: nxt_state = ST_EXEC;
      ST_EXEC:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer and command capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cmd_ff   <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      if (cmd_wr) begin
        cmd_ff <= pwdata[8:0];
      end
    end
  end

  // Accumulator and arithmetic flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 8'h00;
      c_ff   <= 1'b0;
      dc_ff  <= 1'b0;
      z_ff   <= 1'b0;
    end else if (exec) begin
      // result to accumulator when dest clear
      if (!cmd_dest) begin
        acc_ff <= alu_res;
      end
      if (alu_upd_c) begin
        c_ff <= alu_c;
      end
      if (alu_upd_dcz) begin
        dc_ff <= alu_dc;
        z_ff  <= alu_z;
      end
    end else begin
      if (wr_take && (paddr == `ARSS_A_ACC)) begin
        acc_ff <= pwdata[7:0];
      end
      if (stat_wr) begin
        c_ff  <= pwdata[`ARSS_ST_C];
        dc_ff <= pwdata[`ARSS_ST_DC];
        z_ff  <= pwdata[`ARSS_ST_Z];
      end
    end
  end

  // Software setup registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_ff   <= 5'h00;
      wdt_en_ff <= 1'b0;
    end else begin
      if (wr_take && (paddr == `ARSS_A_FSEL)) begin
        fsel_ff <= pwdata[4:0];
      end
      if (ctl_wr) begin
        wdt_en_ff <= pwdata[`ARSS_CT_WDT_EN];
      end
    end
  end

  // Watchdog counter keeps running in sleep, clocked by pclk like the rest of the core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff              <= {PRE_W{1'b0}};
      watchdog_counter_ff <= {WDT_W{1'b0}};
    end else if (slp_cmd) begin
      pre_ff              <= `ARSS_PRE_CLR;
      watchdog_counter_ff <= `ARSS_WDT_CLR;
    end else if (wdt_en_ff) begin
      pre_ff <= pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      if (pre_wrap) begin
        watchdog_counter_ff <= watchdog_counter_ff + {{(WDT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Power state and its status bits; both active low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_status_bit_ff <= 1'b1;
      sleep_status_bit_ff  <= 1'b1;
      asleep_ff            <= 1'b0;
    end else begin
      if (wdt_ovf) begin
        expiry_status_bit_ff <= 1'b0;
      end else if (slp_cmd) begin
        expiry_status_bit_ff <= 1'b1;
      end
      if (slp_cmd) begin
        sleep_status_bit_ff <= 1'b0;
      end
      // enter low power, leave on wake event
      if (slp_cmd) begin
        asleep_ff <= 1'b1;
      end else if (pin_wake || wdt_ovf || sw_wake) begin
        asleep_ff <= 1'b0;
      end
    end
  end

  // Three-stage pin synchroniser; change accepted when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pin_st_ff <= 1'b0;
    end else begin
      pin_s1_ff <= wake_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_st_ff <= pin_s3_ff;
      end
    end
  end

  // wake flag untouched by sleep; set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_wake_flag_ff <= 1'b0;
    end else if (pin_wake) begin
      pin_change_wake_flag_ff <= 1'b1;
    end else if (stat_wr && pwdata[`ARSS_ST_WAKE]) begin
      pin_change_wake_flag_ff <= 1'b0;
    end
  end

  // Read data captured a cycle ahead so prdata comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ok_ff  <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      rd_ok_ff <= psel && !stall && !pready;
      case (paddr)
        `ARSS_A_CMD:   prdata_ff <= {23'h000000, cmd_ff};
        `ARSS_A_ACC:   prdata_ff <= {24'h000000, acc_ff};
        `ARSS_A_STAT:  prdata_ff <= {24'h000000, asleep_ff, busy,
                                     pin_change_wake_flag_ff, sleep_status_bit_ff,
                                     expiry_status_bit_ff, z_ff, dc_ff, c_ff};
        `ARSS_A_FSEL:  prdata_ff <= {27'h0000000, fsel_ff};
        `ARSS_A_FDATA: prdata_ff <= {24'h000000, f_rdata};
        `ARSS_A_WDOG:  prdata_ff <= {{(32-PRE_W-WDT_W){1'b0}}, pre_ff, watchdog_counter_ff};
        `ARSS_A_CTRL:  prdata_ff <= {31'h00000000, wdt_en_ff};
        default:       prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

endmodule // arss_core

`default_nettype wire

// ===== arss_core_asserts.sv
// Port-level checker for the rotate, subtract, swap and sleep datapath
`timescale 1ns/1ps
`default_nettype none
module arss_core_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata_ff,
  input wire logic        wake_pin,
  input wire logic        osc_run,
  input wire logic        low_power
);
  logic slept_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd_taken;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  sequence s_sleep_taken;
    s_cmd_taken ##0 (pwdata[2:0] == 3'h4 && !low_power);
  endsequence
  sequence s_stat_read;
    psel && penable && pready && !pwrite && paddr == 8'h08;
  endsequence
  // Sleep bit has no clear path short of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      slept_ff <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[2:0] == 3'h4)
      slept_ff <= 1'b1;
  end
  a_sleep_halts_osc: assert property (s_sleep_taken |=> ##[0:1] (low_power && !osc_run))
    else $error("oscillator still running after sleep");
  a_osc_vs_lowpwr: assert property (osc_run != low_power)
    else $error("oscillator and low power disagree");
  a_asleep_status: assert property (s_stat_read ##0 low_power |-> prdata_ff[7] && prdata_ff[4:3] == 2'b01)
    else $error("status wrong while asleep");
  a_sleep_bit_low: assert property (s_stat_read ##0 slept_ff |-> !prdata_ff[4])
    else $error("sleep status bit not low after sleep");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready high two cycles");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_ready_bound: assert property ($rose(penable) |-> ##[0:2] pready)
    else $error("access phase too long");
  a_unmapped_err: assert property (pready && (paddr > 8'h18 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access without error");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata_ff == 32'h0)
    else $error("error read returned data");
endmodule // arss_core_asserts

bind arss_core arss_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata_ff(prdata_ff), .wake_pin(wake_pin), .osc_run(osc_run), .low_power(low_power));
`default_nettype wire

// ===== arss_core_tb.sv
// Self-checking bench for the rotate, subtract, swap and sleep datapath
`timescale 1ns/1ps
`default_nettype none
`include "arss_defs.vh"
`define CHK(n, x, y) chk(n, x, y)
module arss_core_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake_pin = 0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  wire logic   pready, pslverr, osc_run, low_power;
  wire [31:0]  prdata_ff;
  int          failures = 0, n_checks = 0;
  // Entries: file operand, acc, result, flags
  logic [31:0] st[3] = '{32'h10010f01, 32'h05050007, 32'h0102ff00};
  always #50 pclk = ~pclk;
  arss_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata_ff(prdata_ff),
    .wake_pin(wake_pin), .osc_run(osc_run), .low_power(low_power));
  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, y);
    end
  endtask
  // Request held until the rising edge that samples pready high; data taken there
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata_ff;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input logic [2:0] op, input logic dst, input logic [4:0] fa);
    apb(`ARSS_A_CMD, 1'b1, {23'h0, fa, dst, op});
    repeat (3) @(posedge pclk);
  endtask
  task setf(input logic [4:0] fa, input logic [7:0] v);
    apb(`ARSS_A_FSEL, 1'b1, {27'h0, fa});
    apb(`ARSS_A_FDATA, 1'b1, {24'h0, v});
  endtask
  task getf(input logic [4:0] fa);
    apb(`ARSS_A_FSEL, 1'b1, {27'h0, fa});
    apb(`ARSS_A_FDATA, 1'b0, 32'h0);
  endtask
  task wait_awake();
    int k;
    for (k = 0; k < 20 && low_power !== 1'b0; k++) @(negedge pclk);
  endtask
  task t_rotate();
    setf(5'd3, 8'h81);
    apb(`ARSS_A_STAT, 1'b1, 32'h07);
    cmd(`ARSS_OP_ROTL, 1'b0, 5'd3);
    apb(`ARSS_A_ACC, 1'b0, 32'h0);
    `CHK("rotl acc", 32'h03, q);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("rotl stat", 32'h1f, q);
    apb(`ARSS_A_STAT, 1'b1, 32'h06);
    cmd(`ARSS_OP_ROTR, 1'b1, 5'd3);
    getf(5'd3);
    `CHK("rotr file", 32'h40, q);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("rotr stat", 32'h1f, q);
    apb(`ARSS_A_ACC, 1'b0, 32'h0);
    `CHK("rotr acc kept", 32'h03, q);
  endtask
  task t_sub();
    for (int i = 0; i < 3; i++) begin
      setf(5'd31, st[i][31:24]);
      apb(`ARSS_A_ACC, 1'b1, {24'h0, st[i][23:16]});
      cmd(`ARSS_OP_SUB, 1'b1, 5'd31);
      getf(5'd31);
      `CHK("sub file", {24'h0, st[i][15:8]}, q);
      apb(`ARSS_A_STAT, 1'b0, 32'h0);
      `CHK("sub stat", {24'h0, st[i][7:0] | 8'h18}, q);
      apb(`ARSS_A_ACC, 1'b0, 32'h0);
      `CHK("sub acc kept", {24'h0, st[i][23:16]}, q);
    end
  endtask
  task t_swap();
    setf(5'd31, 8'ha5);
    apb(`ARSS_A_STAT, 1'b1, 32'h05);
    cmd(`ARSS_OP_SWAP, 1'b0, 5'd31);
    apb(`ARSS_A_ACC, 1'b0, 32'h0);
    `CHK("swap acc", 32'h5a, q);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("swap stat", 32'h1d, q);
    getf(5'd31);
    `CHK("swap file kept", 32'ha5, q);
    cmd(3'h5, 1'b0, 5'd31);
    apb(`ARSS_A_ACC, 1'b0, 32'h0);
    `CHK("pass acc", 32'ha5, q);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("pass stat", 32'h1d, q);
    apb(8'h1c, 1'b0, 32'h0);
    `CHK("unmapped err", 32'h1, {31'h0, e});
    `CHK("unmapped data", 32'h0, q);
  endtask
  task t_sleep();
    apb(`ARSS_A_CTRL, 1'b1, 32'h1);
    // Past one overflow, so sleep has a low expiry bit to raise
    repeat (66000) @(posedge pclk);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("expired", 32'h00, q & 32'h08);
    apb(`ARSS_A_CMD, 1'b1, {29'h0, `ARSS_OP_SLEEP});
    apb(`ARSS_A_WDOG, 1'b0, 32'h0);
    `CHK("wdog cleared", 32'h0, q & 32'hfffff8ff);
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("sleep stat", 32'h88, q & 32'hf8);
    `CHK("osc halted", 32'h1, {31'h0, low_power & ~osc_run});
    cmd(`ARSS_OP_ROTL, 1'b0, 5'd31);
    apb(`ARSS_A_ACC, 1'b0, 32'h0);
    `CHK("cmd while asleep", 32'ha5, q);
    wake_pin <= 1'b1;
    wait_awake();
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("woken stat", 32'h28, q & 32'hf8);
    apb(`ARSS_A_CMD, 1'b1, {29'h0, `ARSS_OP_SLEEP});
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("wake flag kept", 32'ha8, q & 32'hf8);
    apb(`ARSS_A_CTRL, 1'b1, 32'h2);
    wait_awake();
    `CHK("ctrl wake", 32'h1, {31'h0, osc_run});
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #9000000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(`ARSS_A_STAT, 1'b0, 32'h0);
    `CHK("reset stat", 32'h18, q);
    t_rotate();
    t_sub();
    t_swap();
    t_sleep();
    print_verdict();
  end
endmodule // arss_core_tb
`default_nettype wire
